// ---- logic/chpc_pkg.sv ----
`default_nettype none
package chpc_pkg;
    // Clock rate and derived timing.
    localparam int CLK_MHZ = 100;
    localparam int RESET_TIME_NS = 1000;
    localparam int RESET_CYCLES = (RESET_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int IRQ_PULSE_NS = 500;
    localparam int IRQ_PULSE_RAW = (IRQ_PULSE_NS * CLK_MHZ) / 1000;
    localparam int IRQ_PULSE_CYCLES = (IRQ_PULSE_RAW < 1) ? 1 : IRQ_PULSE_RAW;

    // Register byte offsets on the Avalon-MM slave.
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h04;
    localparam logic [4:0] OFS_EVENT = 5'h08;
    localparam logic [4:0] OFS_MASK = 5'h0c;
    localparam logic [4:0] OFS_CFG_OPT = 5'h10;

    // Control register fields.
    localparam int CTRL_W = 4;
    localparam int CTRL_IO_CFG = 0;
    localparam int CTRL_LEVEL = 1;
    localparam int CTRL_IRQ_REQ = 2;
    localparam int CTRL_SW_BUSY = 3;

    // Card configuration option register.
    localparam int CFG_W = 8;
    localparam int CFG_SRST = 7;
    localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

    // Status register fields.
    localparam int STAT_READY = 0;
    localparam int STAT_ATA = 1;
    localparam int STAT_IO = 2;
    localparam int STAT_BUSY = 3;
    localparam int STAT_UDMA = 4;

    // Sticky event bits, shared by the event and mask registers.
    localparam int EV_W = 4;
    localparam int EV_IO_WRITE = 0;
    localparam int EV_IO_READ = 1;
    localparam int EV_BURST_END = 2;
    localparam int EV_RESET_DONE = 3;

    // I/O register file.
    localparam int IO_AW = 3;
    localparam int IO_DEPTH = 1 << IO_AW;

    typedef enum logic [1:0] {
        PH_BUSY = 2'b01,
        PH_READY = 2'b10
    } chpc_phase_type;

    typedef struct packed {
        logic mode_sel_n;
        logic reset_pin;
        logic attr_sel_n;
        logic io_wr_n;
        logic io_rd_n;
        logic oe_n;
        logic stop;
        logic [IO_AW-1:0] addr;
        logic [15:0] data;
    } chpc_pins_type;

    localparam chpc_pins_type PINS_IDLE = '{
        mode_sel_n: 1'b1, reset_pin: 1'b0, attr_sel_n: 1'b1, io_wr_n: 1'b1,
        io_rd_n: 1'b1, oe_n: 1'b1, stop: 1'b0, addr: 3'h0, data: 16'h0000};

    typedef struct packed {
        logic [4:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } chpc_avs_req_type;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } chpc_avs_rsp_type;
endpackage : chpc_pkg
`default_nettype wire

// ---- logic/chpc_card_host_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module chpc_card_host_port #(
    parameter int RESET_CYCLES = chpc_pkg::RESET_CYCLES,
    parameter int PULSE_CYCLES = chpc_pkg::IRQ_PULSE_CYCLES
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Avalon-MM register slave.
    input wire chpc_pkg::chpc_avs_req_type avs_req_i,
    output chpc_pkg::chpc_avs_rsp_type avs_rsp_o,
    output logic irq_o,
    // Host pins.
    input wire chpc_pkg::chpc_pins_type pins_i,
    output logic [15:0] data_o,
    output logic data_oe_o,
    output logic ready_o,
    output logic card_irq_n_o,
    output logic ata_irq_o,
    // Internal transfer engine.
    input wire logic udma_active_i,
    output logic udma_burst_end_o
);
    typedef struct packed {
        chpc_pkg::chpc_pins_type s1;
        chpc_pkg::chpc_pins_type s2;
        chpc_pkg::chpc_pins_type prev;
        chpc_pkg::chpc_phase_type phase;
        logic [15:0] cnt;
        logic powered;
        logic pin_hold;
        logic rst_act_prev;
        logic [chpc_pkg::CTRL_W-1:0] ctrl;
        logic [chpc_pkg::CFG_W-1:0] cfg_opt;
        logic [chpc_pkg::EV_W-1:0] events;
        logic [chpc_pkg::EV_W-1:0] mask;
        logic [chpc_pkg::IO_DEPTH-1:0][15:0] io_file;
        logic [15:0] dout;
        logic drive;
        logic [15:0] pulse_cnt;
        logic irq_req_prev;
        logic card_irq_n;
        logic ata_irq;
        logic burst_end;
        logic ack;
        logic [31:0] rdata;
    } chpc_regs_type;

    localparam chpc_regs_type REGS_RESET = '{
        s1: chpc_pkg::PINS_IDLE,
        s2: chpc_pkg::PINS_IDLE,
        prev: chpc_pkg::PINS_IDLE,
        phase: chpc_pkg::PH_BUSY,
        cnt: 16'(RESET_CYCLES),
        rst_act_prev: 1'b1,
        cfg_opt: chpc_pkg::CFG_RESET,
        card_irq_n: 1'b1,
        default: '0};

    chpc_regs_type r_reg;
    chpc_regs_type r_next;

    function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    logic ata_mode;
    logic io_mode;
    logic mem_mode;
    logic busy;
    logic rst_act;
    logic full_reset;
    logic io_ok;
    logic io_wr_done;
    logic io_rd_start;
    logic io_rd_act;
    logic oe_mem;
    logic oe_io;
    logic stop_rise;
    logic req;
    logic take;
    logic wr_take;
    logic [chpc_pkg::EV_W-1:0] ev_set;
    logic [chpc_pkg::EV_W-1:0] ev_clr;
    logic irq_req;
    logic [31:0] rd_word;

    always_comb begin
        r_next = r_reg;

        // Two-stage synchronisers; only stage two and later feed logic.
        r_next.s1 = pins_i;
        r_next.s2 = r_reg.s1;
        r_next.prev = r_reg.s2;

        // Mode decode from the synchronised select.
        ata_mode = ~r_reg.s2.mode_sel_n;
        io_mode = ~ata_mode & r_reg.ctrl[chpc_pkg::CTRL_IO_CFG];
        mem_mode = ~ata_mode & ~r_reg.ctrl[chpc_pkg::CTRL_IO_CFG];
        busy = (r_reg.phase == chpc_pkg::PH_BUSY);

        // The reset pin changes polarity with the mode.
        rst_act = ata_mode ? ~r_reg.s2.reset_pin : r_reg.s2.reset_pin;
        r_next.rst_act_prev = rst_act;

        // Bus slave: one wait cycle, then the access completes.
        req = avs_req_i.read | avs_req_i.write;
        take = req & r_reg.ack;
        wr_take = take & avs_req_i.write;
        r_next.ack = req & ~r_reg.ack;

        // Edges before the power-up reset completes are ignored, so a pin
        // left asserted from power-up causes no second reset.
        full_reset = 1'b0;
        if (r_reg.powered && rst_act && !r_reg.rst_act_prev) begin
            full_reset = 1'b1;
            r_next.pin_hold = 1'b1;
        end
        if (!rst_act) begin
            r_next.pin_hold = 1'b0;
        end
        if (r_reg.pin_hold && rst_act) begin
            full_reset = 1'b1;
        end
        if (wr_take && hit(avs_req_i.address, chpc_pkg::OFS_CFG_OPT) &&
            avs_req_i.writedata[chpc_pkg::CFG_SRST]) begin
            full_reset = 1'b1;
        end

        // I/O strobes count only in I/O mode with attribute select low,
        // or in native ATA mode, and never while busy.
        io_ok = ~busy & (ata_mode | (io_mode & ~r_reg.s2.attr_sel_n));
        io_wr_done = io_ok & r_reg.s2.io_wr_n & ~r_reg.prev.io_wr_n;
        io_rd_start = io_ok & ~r_reg.s2.io_rd_n & r_reg.prev.io_rd_n;
        io_rd_act = io_ok & ~r_reg.s2.io_rd_n;
        oe_mem = ~busy & mem_mode & ~r_reg.s2.oe_n;
        oe_io = ~busy & io_mode & ~r_reg.s2.oe_n;

        // Data is taken from the sample before the strobe rose, so a host
        // that releases data with the strobe still lands the right word.
        if (io_wr_done) begin
            r_next.io_file[r_reg.prev.addr] = r_reg.prev.data;
        end

        // Common memory reads in memory mode and I/O reads return the register file; attribute
        // space, which every OE read in I/O mode sees, holds the configuration option register at index zero.
        if (io_rd_act || (oe_mem && r_reg.s2.attr_sel_n)) begin
            r_next.dout = r_reg.io_file[r_reg.s2.addr];
        end else if (r_reg.s2.addr == '0) begin
            r_next.dout = {8'h00, r_reg.cfg_opt};
        end else begin
            r_next.dout = 16'h0000;
        end
        r_next.drive = io_rd_act | oe_mem | oe_io;

        // Ultra DMA stop.
        stop_rise = r_reg.s2.stop & ~r_reg.prev.stop;
        r_next.burst_end = ata_mode & udma_active_i & stop_rise;

        // Interrupt request towards the host.
        irq_req = r_reg.ctrl[chpc_pkg::CTRL_IRQ_REQ];
        r_next.irq_req_prev = irq_req;
        if (irq_req && !r_reg.irq_req_prev) begin
            r_next.pulse_cnt = 16'(PULSE_CYCLES);
        end else if (r_reg.pulse_cnt != 16'h0000) begin
            r_next.pulse_cnt = r_reg.pulse_cnt - 16'h0001;
        end
        if (r_reg.ctrl[chpc_pkg::CTRL_LEVEL]) begin
            r_next.card_irq_n = ~(io_mode & irq_req);
        end else begin
            r_next.card_irq_n = ~(io_mode & (r_reg.pulse_cnt != 16'h0000));
        end
        r_next.ata_irq = ata_mode & irq_req;

        // Register writes.
        if (wr_take && hit(avs_req_i.address, chpc_pkg::OFS_CTRL)) begin
            r_next.ctrl = avs_req_i.writedata[chpc_pkg::CTRL_W-1:0];
        end
        if (wr_take && hit(avs_req_i.address, chpc_pkg::OFS_MASK)) begin
            r_next.mask = avs_req_i.writedata[chpc_pkg::EV_W-1:0];
        end
        if (wr_take && hit(avs_req_i.address, chpc_pkg::OFS_CFG_OPT)) begin
            r_next.cfg_opt = avs_req_i.writedata[chpc_pkg::CFG_W-1:0];
            r_next.cfg_opt[chpc_pkg::CFG_SRST] = 1'b0;
        end

        // Reset processing; the sequencer holds ready low throughout.
        ev_set = '0;
        if (full_reset) begin
            r_next.phase = chpc_pkg::PH_BUSY;
            r_next.cnt = 16'(RESET_CYCLES);
            r_next.ctrl = '0;
            r_next.cfg_opt = chpc_pkg::CFG_RESET;
            r_next.io_file = '0;
            r_next.pulse_cnt = 16'h0000;
        end else begin
            case (r_reg.phase)
                chpc_pkg::PH_BUSY: begin
                    if (r_reg.cnt <= 16'h0001) begin
                        r_next.phase = chpc_pkg::PH_READY;
                        r_next.cnt = 16'h0000;
                        r_next.powered = 1'b1;
                        ev_set[chpc_pkg::EV_RESET_DONE] = 1'b1;
                    end else begin
                        r_next.cnt = r_reg.cnt - 16'h0001;
                    end
                end
                chpc_pkg::PH_READY: begin
                    r_next.cnt = 16'h0000;
                end
                default: begin
                    r_next.phase = chpc_pkg::PH_BUSY;
                    r_next.cnt = 16'(RESET_CYCLES);
                end
            endcase
        end

        // Sticky events: a new event outranks a clear in the same cycle.
        ev_set[chpc_pkg::EV_IO_WRITE] = io_wr_done;
        ev_set[chpc_pkg::EV_IO_READ] = io_rd_start;
        ev_set[chpc_pkg::EV_BURST_END] = r_next.burst_end;
        ev_clr = '0;
        if (wr_take && hit(avs_req_i.address, chpc_pkg::OFS_EVENT)) begin
            ev_clr = avs_req_i.writedata[chpc_pkg::EV_W-1:0];
        end
        r_next.events = (r_reg.events & ~ev_clr) | ev_set;

        // Read data is captured in the wait cycle and held to completion.
        rd_word = 32'h0000_0000;
        case (avs_req_i.address)
            chpc_pkg::OFS_CTRL: begin
                rd_word[chpc_pkg::CTRL_W-1:0] = r_reg.ctrl;
            end
            chpc_pkg::OFS_STATUS: begin
                rd_word[chpc_pkg::STAT_READY] = ready_o;
                rd_word[chpc_pkg::STAT_ATA] = ata_mode;
                rd_word[chpc_pkg::STAT_IO] = io_mode;
                rd_word[chpc_pkg::STAT_BUSY] = busy;
                rd_word[chpc_pkg::STAT_UDMA] = udma_active_i;
            end
            chpc_pkg::OFS_EVENT: begin
                rd_word[chpc_pkg::EV_W-1:0] = r_reg.events;
            end
            chpc_pkg::OFS_MASK: begin
                rd_word[chpc_pkg::EV_W-1:0] = r_reg.mask;
            end
            chpc_pkg::OFS_CFG_OPT: begin
                rd_word[chpc_pkg::CFG_W-1:0] = r_reg.cfg_opt;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
        if (req && !r_reg.ack) begin
            r_next.rdata = rd_word;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            r_reg <= REGS_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // Ready reflects reset processing and the firmware busy flag; in the
    // other modes the pin is unused but still driven to the same value.
    assign ready_o = (r_reg.phase == chpc_pkg::PH_READY) &
        ~r_reg.ctrl[chpc_pkg::CTRL_SW_BUSY];
    assign data_o = r_reg.dout;
    assign data_oe_o = r_reg.drive;
    assign card_irq_n_o = r_reg.card_irq_n;
    assign ata_irq_o = r_reg.ata_irq;
    assign udma_burst_end_o = r_reg.burst_end;
    assign irq_o = |(r_reg.events & r_reg.mask);
    assign avs_rsp_o.readdata = r_reg.rdata;
    assign avs_rsp_o.waitrequest = req & ~r_reg.ack;
endmodule : chpc_card_host_port
`default_nettype wire

// ---- verif/chpc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module chpc_host_model (
    // Clock and device status.
    input wire logic clk_i,
    input wire logic ready_i,
    // Host pins.
    output var chpc_pkg::chpc_pins_type pins_o
);
    initial pins_o = chpc_pkg::PINS_IDLE;
    // No limit of its own: a ready that never comes is caught by the bench watchdog.
    task wait_ready();
        @(posedge clk_i);
        while (ready_i !== 1'b1) begin
            @(posedge clk_i);
        end
    endtask : wait_ready
    // The reset pin flips its sense with the mode, so both move together.
    task set_mode(input logic ata);
        @(posedge clk_i);
        pins_o.mode_sel_n <= ~ata;
        pins_o.reset_pin <= ata;
    endtask : set_mode
    task set_reset(input logic v);
        @(posedge clk_i);
        pins_o.reset_pin <= v;
    endtask : set_reset
    task io_write(input logic [2:0] a, input logic [15:0] d);
        wait_ready();
        pins_o.addr <= a;
        pins_o.data <= d;
        pins_o.attr_sel_n <= 1'b0;
        pins_o.io_wr_n <= 1'b0;
        repeat (5) @(posedge clk_i);
        pins_o.io_wr_n <= 1'b1;
        repeat (3) @(posedge clk_i);
        // Released data lines must not keep showing the written word.
        pins_o.data <= ~d;
        pins_o.attr_sel_n <= 1'b1;
    endtask : io_write
    task strobe(input logic oe, input logic [2:0] a, input logic attr_n, input logic low);
        if (low) begin
            wait_ready();
        end else begin
            @(posedge clk_i);
        end
        pins_o.addr <= a;
        pins_o.attr_sel_n <= attr_n;
        if (oe) begin
            pins_o.oe_n <= ~low;
        end else begin
            pins_o.io_rd_n <= ~low;
        end
    endtask : strobe
    task stop_pulse();
        @(posedge clk_i);
        pins_o.stop <= 1'b1;
        repeat (4) @(posedge clk_i);
        pins_o.stop <= 1'b0;
    endtask : stop_pulse
endmodule : chpc_host_model
`default_nettype wire

// ---- verif/chpc_card_host_port_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module chpc_card_host_port_checker #(
    parameter int RESET_CYCLES = chpc_pkg::RESET_CYCLES,
    parameter int PULSE_CYCLES = chpc_pkg::IRQ_PULSE_CYCLES
) (
    // Clock, reset and register bus.
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire chpc_pkg::chpc_avs_req_type avs_req_i,
    input wire chpc_pkg::chpc_avs_rsp_type avs_rsp_o,
    input wire logic irq_o,
    // Host pins and transfer engine.
    input wire chpc_pkg::chpc_pins_type pins_i,
    input wire logic [15:0] data_o,
    input wire logic data_oe_o,
    input wire logic ready_o,
    input wire logic card_irq_n_o,
    input wire logic ata_irq_o,
    input wire logic udma_active_i,
    input wire logic udma_burst_end_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic rd_low = !pins_i.io_rd_n || !pins_i.oe_n;
    wire logic req_on = avs_req_i.read || avs_req_i.write;
    property p_ready_busy;
        $rose(rst_n_i) |-> !ready_o [*3];
    endproperty
    a_ready_busy: assert property (p_ready_busy) else $error("ready high after reset");
    property p_reset_quiet;
        $rose(rst_n_i) |-> !data_oe_o && card_irq_n_o && !ata_irq_o && !irq_o;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");
    property p_drive_cause;
        data_oe_o |-> $past(rd_low, 3);
    endproperty
    a_drive_cause: assert property (p_drive_cause) else $error("bus driven without strobe");
    property p_burst_one;
        udma_burst_end_o |=> !udma_burst_end_o;
    endproperty
    a_burst_one: assert property (p_burst_one) else $error("burst end too long");
    property p_burst_active;
        udma_burst_end_o |-> $past(udma_active_i);
    endproperty
    a_burst_active: assert property (p_burst_active) else $error("burst end when idle");
    property p_irq_excl;
        !card_irq_n_o |-> !ata_irq_o;
    endproperty
    a_irq_excl: assert property (p_irq_excl) else $error("both interrupt outputs on");
    property p_wait_first;
        $rose(req_on) |-> avs_rsp_o.waitrequest;
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("no wait in first cycle");
    property p_wait_ack;
        $rose(req_on) |=> !avs_rsp_o.waitrequest;
    endproperty
    a_wait_ack: assert property (p_wait_ack) else $error("no answer in second cycle");
    c_drive: cover property (data_oe_o);
    c_burst: cover property (udma_burst_end_o);
    c_card_irq: cover property ($fell(card_irq_n_o));
endmodule : chpc_card_host_port_checker
bind chpc_card_host_port chpc_card_host_port_checker #(
    .RESET_CYCLES(RESET_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) u_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_req_i(avs_req_i), .avs_rsp_o(avs_rsp_o),
    .irq_o(irq_o), .pins_i(pins_i), .data_o(data_o), .data_oe_o(data_oe_o),
    .ready_o(ready_o), .card_irq_n_o(card_irq_n_o), .ata_irq_o(ata_irq_o),
    .udma_active_i(udma_active_i), .udma_burst_end_o(udma_burst_end_o));
`default_nettype wire

// ---- verif/test_card_host_port_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_card_host_port_control;
    localparam int RC = 4;
    localparam int PC = 3;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic udma_i = 1'b0;
    chpc_pkg::chpc_avs_req_type req = '0;
    chpc_pkg::chpc_avs_rsp_type rsp;
    chpc_pkg::chpc_pins_type pins;
    logic irq_o;
    logic oe_o;
    logic ready_o;
    logic cirq_n;
    logic airq;
    logic bend;
    logic [15:0] data_o;
    logic [31:0] rd;
    int err_count = 0;
    int cmp_count = 0;
    int n;
    chpc_card_host_port #(.RESET_CYCLES(RC), .PULSE_CYCLES(PC)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_req_i(req), .avs_rsp_o(rsp), .irq_o(irq_o),
        .pins_i(pins), .data_o(data_o), .data_oe_o(oe_o), .ready_o(ready_o),
        .card_irq_n_o(cirq_n), .ata_irq_o(airq), .udma_active_i(udma_i),
        .udma_burst_end_o(bend));
    chpc_host_model host (.clk_i(clk_i), .ready_i(ready_o), .pins_o(pins));
    initial forever #5 clk_i = ~clk_i;
    task give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task look(input int c);
        repeat (c) @(posedge clk_i);
        @(negedge clk_i);
    endtask : look
    // Waitrequest and read data are taken at the rising edge, before that edge's updates land.
    task av(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_i);
        req <= '{address: a, read: ~wr, write: wr, writedata: d};
        do begin
            @(posedge clk_i);
        end while (rsp.waitrequest !== 1'b0);
        rd = rsp.readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask : av
    task stop_count(output int c);
        c = 0;
        fork
            host.stop_pulse();
            repeat (12) begin
                @(negedge clk_i);
                if (bend === 1'b1) c++;
            end
        join
    endtask : stop_count
    task t_io();
        av(1'b1, 5'h00, 32'h1);
        av(1'b1, 5'h0c, 32'h1);
        host.io_write(3'h3, 16'h5a3c);
        look(4);
        chk(irq_o, 1'b1);
        av(1'b1, 5'h0c, 32'h0);
        look(1);
        chk(irq_o, 1'b0);
        av(1'b1, 5'h08, 32'hf);
        host.strobe(1'b0, 3'h3, 1'b0, 1'b1);
        look(5);
        chk({oe_o, data_o}, 17'h15a3c);
        host.strobe(1'b0, 3'h3, 1'b1, 1'b0);
        av(1'b1, 5'h10, 32'h15);
        host.strobe(1'b1, 3'h0, 1'b0, 1'b1);
        look(5);
        chk({oe_o, data_o}, 17'h10015);
        host.strobe(1'b1, 3'h0, 1'b1, 1'b0);
        av(1'b1, 5'h00, 32'h0);
        host.strobe(1'b1, 3'h3, 1'b1, 1'b1);
        look(5);
        chk({oe_o, data_o}, 17'h15a3c);
        host.strobe(1'b1, 3'h3, 1'b1, 1'b0);
        host.strobe(1'b1, 3'h0, 1'b0, 1'b1);
        look(5);
        chk({oe_o, data_o}, 17'h10015);
        host.strobe(1'b1, 3'h0, 1'b1, 1'b0);
        host.strobe(1'b0, 3'h3, 1'b1, 1'b1);
        look(5);
        chk(oe_o, 1'b0);
        host.strobe(1'b0, 3'h3, 1'b1, 1'b0);
        $display("strobe test done");
    endtask : t_io
    task t_irq();
        av(1'b1, 5'h00, 32'h1);
        av(1'b1, 5'h00, 32'h5);
        n = 0;
        repeat (20) begin
            @(negedge clk_i);
            if (cirq_n === 1'b0) n++;
        end
        chk(n, PC);
        av(1'b1, 5'h00, 32'h7);
        look(3);
        chk({cirq_n, airq}, 2'b00);
        av(1'b1, 5'h00, 32'h3);
        look(3);
        chk(cirq_n, 1'b1);
        av(1'b1, 5'h00, 32'h8);
        look(1);
        chk(ready_o, 1'b0);
        av(1'b1, 5'h00, 32'h0);
        look(1);
        chk(ready_o, 1'b1);
        $display("interrupt test done");
    endtask : t_irq
    task t_ata();
        av(1'b1, 5'h00, 32'h0);
        host.set_mode(1'b1);
        av(1'b1, 5'h00, 32'h4);
        look(3);
        chk({airq, cirq_n}, 2'b11);
        @(posedge clk_i);
        udma_i <= 1'b1;
        stop_count(n);
        chk(n, 1);
        @(posedge clk_i);
        udma_i <= 1'b0;
        stop_count(n);
        chk(n, 0);
        host.set_reset(1'b0);
        look(6);
        chk(ready_o, 1'b0);
        host.set_reset(1'b1);
        host.wait_ready();
        av(1'b0, 5'h00, 32'h0);
        chk(rd, 32'h0);
        $display("native mode test done");
    endtask : t_ata
    task t_soft();
        host.set_mode(1'b0);
        av(1'b1, 5'h00, 32'h1);
        av(1'b1, 5'h10, 32'h80);
        look(2);
        chk(ready_o, 1'b0);
        host.wait_ready();
        av(1'b0, 5'h00, 32'h0);
        chk(rd, 32'h0);
        host.set_reset(1'b1);
        look(6);
        chk(ready_o, 1'b0);
        host.set_reset(1'b0);
        host.wait_ready();
        look(0);
        chk(ready_o, 1'b1);
        $display("reset test done");
    endtask : t_soft
    initial begin
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        look(1);
        chk(ready_o, 1'b0);
        host.wait_ready();
        av(1'b0, 5'h08, 32'h0);
        chk(rd[3], 1'b1);
        av(1'b1, 5'h08, 32'hf);
        t_io();
        t_irq();
        t_ata();
        t_soft();
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        give_verdict();
    end
endmodule : test_card_host_port_control
`default_nettype wire
